/* File: rtl/cdb_output_stage.sv */
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - dead time only when both output enables and main output enable are set
// - each channel has its own 10-bit dead-time generator from the reference
// - primary output follows reference, rising edge delayed by dead time
// - complementary output is inverted reference, rising edge delayed
// - pulses shorter than the dead time are suppressed entirely
// - one shared dead-time code applies to all channels
// - complementary alone follows reference xor polarity, not inverted
// - run mode, off-state clear: disabled output undriven, enabled polarised
// - run mode, off-state set: disabled output driven at inactive level
// - both enables clear under main enable: neither output driven
// - main enable clear: release pins or hold idle levels per select
// - primary and complementary never active together
// - two brake pins, each with polarity and optional digital filter
// - software brake bits raise brake events regardless of brake enables
// - unfiltered brake pin clears main output enable asynchronously, without clock
// - brake forces outputs inactive, brake 1 then idle levels after dead time
// - resynchronised main enable may lengthen the idle dead time
// - brake sets its status flag; interrupt when enabled
// - auto re-enable sets main enable on the next update event
// - active brake blocks main enable set and flag clearing
// - brake 1 leads to safe state, brake 2 only inactive; brake 1 wins
// - three lock levels freeze configuration except the brake interrupt enable; lock field written once
// - per-output polarity bit selects active high or active low
module cdb_output_stage
   import cdb_pkg::*;
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // reference waveforms and timer events
   input wire logic [NUM_CH-1:0] ref_wave,
   input wire logic update_event,
   // fault pins of the power stage
   input wire logic brake_pin_1,
   input wire logic brake_pin_2,
   // channel pins
   output logic [NUM_CH-1:0] primary_out,
   output logic [NUM_CH-1:0] primary_out_oe,
   output logic [NUM_CH-1:0] compl_out,
   output logic [NUM_CH-1:0] compl_out_oe,
   // status
   output logic brake_irq,
   output logic main_out_en
);
   logic [NUM_CH-1:0] primary_out_en_reg, compl_out_en_reg;
   logic [NUM_CH-1:0] primary_polarity_reg, compl_polarity_reg;
   logic [NUM_CH-1:0] primary_idle_level_reg, compl_idle_level_reg;
   logic [DT_W-1:0] deadtime_code_reg;
   logic idle_off_state_sel_reg, run_off_state_sel_reg;
   logic [1:0] brake_en_reg, brake_pol_reg, brake_filt_reg;
   logic auto_out_reenable_reg, brake_irq_en_reg;
   logic [1:0] lock_reg;
   logic lock_done_reg;
   logic main_out_en_reg, main_prev_reg;
   logic [1:0] brake_flag_reg;
   logic [DT_W-1:0] idle_cnt_reg;
   logic idle_ok_reg;
   logic [1:0] filt_lvl_reg;
   logic [2:0] filt_cnt_reg [2];
   logic [DATA_W-1:0] rd_data;
   logic mapped, access, wr;
   logic [1:0] brake_raw, brake_lvl, sw_brake, brake_evt;
   logic brake_any, upd, brake_async_n, idle_ready;
   logic lk1, lk2, lk3;

   // apb handshake: one wait state, request taken when pready is high
   assign access = psel & penable & pready;
   assign wr = access & pwrite;
   assign lk1 = (lock_reg >= LOCK_L1);
   assign lk2 = (lock_reg >= LOCK_L2);
   assign lk3 = (lock_reg == LOCK_L3);

   always_comb begin
      rd_data = DATA_ZERO;
      mapped = 1'b1;
      if (paddr == OFS_OUTCTL) begin
         for (int i = 0; i < NUM_CH; i++) begin
            rd_data[OC_STRIDE*i+OC_PEN] = primary_out_en_reg[i];
            rd_data[OC_STRIDE*i+OC_NEN] = compl_out_en_reg[i];
            rd_data[OC_STRIDE*i+OC_PPOL] = primary_polarity_reg[i];
            rd_data[OC_STRIDE*i+OC_NPOL] = compl_polarity_reg[i];
            rd_data[IDL_BASE+IDL_STRIDE*i] = primary_idle_level_reg[i];
            rd_data[IDL_BASE+IDL_STRIDE*i+1] = compl_idle_level_reg[i];
         end
      end else if (paddr == OFS_BRAKEDT) begin
         rd_data[BD_DT +: DT_W] = deadtime_code_reg;
         rd_data[BD_IDLE_OFF] = idle_off_state_sel_reg;
         rd_data[BD_RUN_OFF] = run_off_state_sel_reg;
         for (int b = 0; b < 2; b++) begin
            rd_data[BD_BRAKE_BASE+BD_BRAKE_STRIDE*b+BD_B_EN] = brake_en_reg[b];
            rd_data[BD_BRAKE_BASE+BD_BRAKE_STRIDE*b+BD_B_POL] = brake_pol_reg[b];
            rd_data[BD_BRAKE_BASE+BD_BRAKE_STRIDE*b+BD_B_FILT] =
               brake_filt_reg[b];
         end
         rd_data[BD_AUTO] = auto_out_reenable_reg;
         rd_data[BD_IRQ_EN] = brake_irq_en_reg;
         rd_data[BD_LOCK +: 2] = lock_reg;
         rd_data[BD_MAIN_EN] = main_out_en_reg;
      end else if (paddr == OFS_EVENT) begin
         rd_data = DATA_ZERO;
      end else if (paddr == OFS_STATUS) begin
         rd_data[ST_FLAG +: 2] = brake_flag_reg;
         rd_data[ST_LEVEL +: 2] = brake_lvl;
         rd_data[ST_MAIN_EN] = main_out_en_reg;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= DATA_ZERO;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata <= (psel & penable & ~pready & ~pwrite) ? rd_data : DATA_ZERO;
      end
   end

   // configuration, frozen field by field by the lock level; brake interrupt enable never frozen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_out_en_reg <= '0;
         compl_out_en_reg <= '0;
         primary_polarity_reg <= '0;
         compl_polarity_reg <= '0;
         primary_idle_level_reg <= '0;
         compl_idle_level_reg <= '0;
         deadtime_code_reg <= DT_ZERO;
         idle_off_state_sel_reg <= 1'b0;
         run_off_state_sel_reg <= 1'b0;
         brake_en_reg <= 2'h0;
         brake_pol_reg <= 2'h0;
         brake_filt_reg <= 2'h0;
         auto_out_reenable_reg <= 1'b0;
         brake_irq_en_reg <= 1'b0;
         lock_reg <= LOCK_OFF;
         lock_done_reg <= 1'b0;
      end else if (wr && paddr == OFS_OUTCTL) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (!lk3) begin
               primary_out_en_reg[i] <= pwdata[OC_STRIDE*i+OC_PEN];
               compl_out_en_reg[i] <= pwdata[OC_STRIDE*i+OC_NEN];
            end
            if (!lk2) begin
               primary_polarity_reg[i] <= pwdata[OC_STRIDE*i+OC_PPOL];
               compl_polarity_reg[i] <= pwdata[OC_STRIDE*i+OC_NPOL];
            end
            if (!lk1) begin
               primary_idle_level_reg[i] <= pwdata[IDL_BASE+IDL_STRIDE*i];
               compl_idle_level_reg[i] <= pwdata[IDL_BASE+IDL_STRIDE*i+1];
            end
         end
      end else if (wr && paddr == OFS_BRAKEDT) begin
         if (!lk1) begin
            deadtime_code_reg <= pwdata[BD_DT +: DT_W];
            auto_out_reenable_reg <= pwdata[BD_AUTO];
            for (int b = 0; b < 2; b++) begin
               brake_en_reg[b] <= pwdata[BD_BRAKE_BASE+BD_BRAKE_STRIDE*b+BD_B_EN];
               brake_pol_reg[b] <=
                  pwdata[BD_BRAKE_BASE+BD_BRAKE_STRIDE*b+BD_B_POL];
               brake_filt_reg[b] <=
                  pwdata[BD_BRAKE_BASE+BD_BRAKE_STRIDE*b+BD_B_FILT];
            end
         end
         if (!lk2) begin
            idle_off_state_sel_reg <= pwdata[BD_IDLE_OFF];
            run_off_state_sel_reg <= pwdata[BD_RUN_OFF];
         end
         brake_irq_en_reg <= pwdata[BD_IRQ_EN];
         // lock accepts its first write only
         if (!lock_done_reg) begin
            lock_reg <= pwdata[BD_LOCK +: 2];
            lock_done_reg <= 1'b1;
         end
      end
   end

   // brake inputs: polarity, enable, optional filter
   assign sw_brake[0] = wr && paddr == OFS_EVENT && pwdata[EV_SW_BRAKE];
   assign sw_brake[1] = wr && paddr == OFS_EVENT && pwdata[EV_SW_BRAKE+1];
   assign upd = update_event | (wr && paddr == OFS_EVENT && pwdata[EV_UPDATE]);
   assign brake_raw[0] = (brake_pin_1 ^ brake_pol_reg[0]) & brake_en_reg[0];
   assign brake_raw[1] = (brake_pin_2 ^ brake_pol_reg[1]) & brake_en_reg[1];

   generate
      for (genvar b = 0; b < 2; b++) begin : g_brake
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               filt_cnt_reg[b] <= 3'h0;
               filt_lvl_reg[b] <= 1'b0;
            end else if (brake_raw[b] == filt_lvl_reg[b]) begin
               filt_cnt_reg[b] <= 3'h0;
            end else if (filt_cnt_reg[b] == FILT_LAST) begin
               filt_cnt_reg[b] <= 3'h0;
               filt_lvl_reg[b] <= brake_raw[b];
            end else begin
               filt_cnt_reg[b] <= filt_cnt_reg[b] + 3'h1;
            end
         end
         assign brake_lvl[b] = brake_filt_reg[b] ? filt_lvl_reg[b] : brake_raw[b];
         assign brake_evt[b] = brake_lvl[b] | sw_brake[b];
      end
   endgenerate

   assign brake_any = |brake_evt;
   // unfiltered pins act with no clock at all; a filtered pin waits for it
   assign brake_async_n = presetn & ~(brake_raw[0] & ~brake_filt_reg[0])
      & ~(brake_raw[1] & ~brake_filt_reg[1]);

   // main output enable
   always_ff @(posedge pclk or negedge brake_async_n) begin
      if (!brake_async_n) begin
         main_out_en_reg <= 1'b0;
      end else if (brake_any) begin
         main_out_en_reg <= 1'b0;
      end else if (wr && paddr == OFS_BRAKEDT) begin
         main_out_en_reg <= pwdata[BD_MAIN_EN];
      end else if (auto_out_reenable_reg && upd) begin
         main_out_en_reg <= 1'b1;
      end
   end
   assign main_out_en = main_out_en_reg;

   // brake flags: set wins over clear, no clear while the level stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brake_flag_reg <= 2'h0;
         brake_irq <= 1'b0;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (brake_evt[b]) begin
               brake_flag_reg[b] <= 1'b1;
            end else if (wr && paddr == OFS_STATUS && pwdata[ST_FLAG+b]
                         && !brake_lvl[b]) begin
               brake_flag_reg[b] <= 1'b0;
            end
         end
         brake_irq <= brake_irq_en_reg & (|brake_flag_reg);
      end
   end

   // idle dead time after the enable drops; resync adds a cycle only when the dead-time code is zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_prev_reg <= 1'b0;
         idle_cnt_reg <= DT_ZERO;
         idle_ok_reg <= 1'b1;
      end else begin
         main_prev_reg <= main_out_en_reg;
         if (main_out_en_reg) begin
            idle_cnt_reg <= deadtime_code_reg;
         end else if (idle_cnt_reg != DT_ZERO) begin
            idle_cnt_reg <= idle_cnt_reg - 10'h001;
         end
         if (brake_evt[0]) begin
            idle_ok_reg <= 1'b1;
         end else if (brake_evt[1]) begin
            idle_ok_reg <= 1'b0;
         end else if (main_out_en_reg) begin
            idle_ok_reg <= 1'b1;
         end
      end
   end
   assign idle_ready = !main_out_en_reg && !main_prev_reg
      && idle_cnt_reg == DT_ZERO && idle_ok_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   brake_clear_a: assert property (brake_any |=> !main_out_en_reg)
      else $error("main enable not cleared by brake");
   brake_hold_a: assert property (brake_lvl[0] && brake_lvl[1] |=>
      !main_out_en_reg ##0 brake_flag_reg == 2'h3)
      else $error("brake level did not hold enable low and flags set");
   sw_brake_a: assert property (sw_brake[1] && !brake_en_reg[1] |=>
      brake_flag_reg[1])
      else $error("software brake did not set flag");
   auto_on_a: assert property (auto_out_reenable_reg && upd && !brake_any
      && !(wr && paddr == OFS_BRAKEDT) |=> main_out_en_reg)
      else $error("auto re-enable missed update event");
   irq_out_a: assert property (brake_evt[0] && brake_irq_en_reg
      ##1 brake_irq_en_reg |=> brake_irq)
      else $error("brake interrupt not raised");
   lock_once_a: assert property (lock_done_reg |=> $stable(lock_reg))
      else $error("lock field changed after first write");

   // per channel dead-time generator and output stage
   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         logic ref_prev_reg, p_act_reg, n_act_reg, p_next, n_next;
         logic p_idle_reg, n_idle_reg;
         logic [DT_W-1:0] dt_cnt_reg;
         logic dt_ok;
         logic both_en;

         assign both_en = primary_out_en_reg[i] & compl_out_en_reg[i];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ref_prev_reg <= 1'b0;
               dt_cnt_reg <= DT_ZERO;
            end else begin
               ref_prev_reg <= ref_wave[i];
               if (ref_wave[i] != ref_prev_reg) begin
                  dt_cnt_reg <= deadtime_code_reg;
               end else if (dt_cnt_reg != DT_ZERO) begin
                  dt_cnt_reg <= dt_cnt_reg - 10'h001;
               end
            end
         end
         assign dt_ok = (dt_cnt_reg == DT_ZERO);

         always_comb begin
            p_next = 1'b0;
            n_next = 1'b0;
            if (main_out_en_reg && both_en) begin
               p_next = ref_prev_reg & dt_ok;
               n_next = ~ref_prev_reg & dt_ok;
            end else if (main_out_en_reg) begin
               p_next = primary_out_en_reg[i] & ref_prev_reg;
               n_next = compl_out_en_reg[i] & ref_prev_reg;
            end
         end

         // idle levels sit in flops the brake does not force, so they can
         // appear after the dead time while the brake level still stands
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               p_idle_reg <= 1'b0;
               n_idle_reg <= 1'b0;
            end else begin
               p_idle_reg <= idle_ready
                  & primary_idle_level_reg[i];
               n_idle_reg <= idle_ready & compl_idle_level_reg[i]
                  & ~primary_idle_level_reg[i];
            end
         end

         always_ff @(posedge pclk or negedge brake_async_n) begin
            if (!brake_async_n) begin
               p_act_reg <= 1'b0;
               n_act_reg <= 1'b0;
            end else begin
               p_act_reg <= p_next;
               n_act_reg <= n_next;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               primary_out_oe[i] <= 1'b0;
               compl_out_oe[i] <= 1'b0;
            end else if (!(primary_out_en_reg[i] | compl_out_en_reg[i])) begin
               primary_out_oe[i] <= 1'b0;
               compl_out_oe[i] <= 1'b0;
            end else if (main_out_en_reg) begin
               primary_out_oe[i] <= primary_out_en_reg[i] | run_off_state_sel_reg;
               compl_out_oe[i] <= compl_out_en_reg[i] | run_off_state_sel_reg;
            end else begin
               primary_out_oe[i] <= idle_off_state_sel_reg;
               compl_out_oe[i] <= idle_off_state_sel_reg;
            end
         end
         assign primary_out[i] = (p_act_reg | p_idle_reg)
            ^ primary_polarity_reg[i];
         assign compl_out[i] = (n_act_reg | n_idle_reg)
            ^ compl_polarity_reg[i];

         sequence ref_rise_s;
            $rose(ref_wave[i]) && main_out_en_reg && both_en
               && deadtime_code_reg != DT_ZERO;
         endsequence
         sequence held_low_s;
            !p_act_reg ##1 !p_act_reg;
         endsequence
         dt_delay_a: assert property (ref_rise_s ##1 main_out_en_reg
            |-> held_low_s)
            else $error("primary rose before dead time");
         no_overlap_a: assert property (!((p_act_reg || p_idle_reg)
            && (n_act_reg || n_idle_reg)))
            else $error("both outputs active together");
         idle_rel_a: assert property (!main_out_en_reg
            && !idle_off_state_sel_reg |=> !primary_out_oe[i])
            else $error("pin not released in idle");
      end
   endgenerate
endmodule : cdb_output_stage
`default_nettype wire

/* File: rtl/cdb_pkg.sv */
package cdb_pkg;
   // channel count and dead-time counter width
   localparam int NUM_CH = 4;
   localparam int DT_W = 10;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_OUTCTL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_BRAKEDT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_EVENT = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

   // output control: per channel group of four, idle levels above
   localparam int OC_PEN = 0;
   localparam int OC_NEN = 1;
   localparam int OC_PPOL = 2;
   localparam int OC_NPOL = 3;
   localparam int OC_STRIDE = 4;
   localparam int IDL_BASE = 16;
   localparam int IDL_STRIDE = 2;

   // brake and dead-time register
   localparam int BD_DT = 0;
   localparam int BD_IDLE_OFF = 10;
   localparam int BD_RUN_OFF = 11;
   localparam int BD_BRAKE_BASE = 12;
   localparam int BD_BRAKE_STRIDE = 3;
   localparam int BD_B_EN = 0;
   localparam int BD_B_POL = 1;
   localparam int BD_B_FILT = 2;
   localparam int BD_AUTO = 18;
   localparam int BD_IRQ_EN = 19;
   localparam int BD_LOCK = 20;
   localparam int BD_MAIN_EN = 24;

   // event register (write only) and status register
   localparam int EV_SW_BRAKE = 0;
   localparam int EV_UPDATE = 2;
   localparam int ST_FLAG = 0;
   localparam int ST_LEVEL = 2;
   localparam int ST_MAIN_EN = 4;

   // write protection levels
   localparam logic [1:0] LOCK_OFF = 2'h0;
   localparam logic [1:0] LOCK_L1 = 2'h1;
   localparam logic [1:0] LOCK_L2 = 2'h2;
   localparam logic [1:0] LOCK_L3 = 2'h3;

   // brake filter: level must be stable for FILT_LAST+1 samples
   localparam logic [2:0] FILT_LAST = 3'h7;
   localparam logic [DT_W-1:0] DT_ZERO = 10'h000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
endpackage : cdb_pkg

/* File: testbench/cdb_power_stage.sv */
`timescale 1ns/1ps
`default_nettype none
// power switch stage: faults on command, fault 1 also when a leg shoots through
module cdb_power_stage
   import cdb_pkg::*;
(
   // gate drive from the block
   input wire logic [NUM_CH-1:0] hi_gate,
   input wire logic [NUM_CH-1:0] hi_oe,
   input wire logic [NUM_CH-1:0] lo_gate,
   input wire logic [NUM_CH-1:0] lo_oe,
   // fault requests from the bench
   input wire logic fault_cmd_1,
   input wire logic fault_cmd_2,
   // fault outputs, active high, always driven
   output logic fault_1,
   output logic fault_2
);
   logic shoot;
   // both switches of one leg on would short the supply
   assign shoot = |(hi_gate & hi_oe & lo_gate & lo_oe);
   assign fault_1 = fault_cmd_1 | shoot;
   assign fault_2 = fault_cmd_2;
endmodule : cdb_power_stage
`default_nettype wire

/* File: testbench/complementary_deadtime_brake_output_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module complementary_deadtime_brake_output_tb;
   import cdb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [NUM_CH-1:0] ref_wave, p_out, p_oe, c_out, c_oe;
   logic update_event, brake_irq, main_out_en, pin_1, pin_2, f1, f2;
   logic [1:0] seen;
   int n_fail, total_checks;
   localparam int DT = 5;

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   cdb_output_stage i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_wave(ref_wave), .update_event(update_event),
      .brake_pin_1(pin_1), .brake_pin_2(pin_2), .primary_out(p_out),
      .primary_out_oe(p_oe), .compl_out(c_out), .compl_out_oe(c_oe),
      .brake_irq(brake_irq), .main_out_en(main_out_en));

   cdb_power_stage i_stage (.hi_gate(p_out), .hi_oe(p_oe), .lo_gate(c_out),
      .lo_oe(c_oe), .fault_cmd_1(f1), .fault_cmd_2(f2), .fault_1(pin_1),
      .fault_2(pin_2));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chb(input logic got, input logic exp);
      chk({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask : chb

   // waits on pready, never on a fixed count
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_fail++;
      end
   endtask : apb

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
         input logic [31:0] mask);
      apb(1'b0, a, DATA_ZERO);
      chk(rd & mask, exp);
   endtask : rdc

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : cyc

   task automatic pulse_update;
      @(posedge pclk);
      update_event <= 1'b1;
      @(posedge pclk);
      update_event <= 1'b0;
      cyc(2);
   endtask : pulse_update

   initial begin
      #(100 * 5000);
      n_fail++;
      stop_test();
   end

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      ref_wave = '0;
      update_event = 1'b0;
      f1 = 1'b0;
      f2 = 1'b0;
      presetn = 1'b0;
      n_fail = 0;
      total_checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(OFS_OUTCTL, 32'h0000_0000, 32'hFFFF_FFFF);
      rdc(OFS_BRAKEDT, 32'h0000_0000, 32'hFFFF_FFFF);
      rdc(OFS_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
      apb(1'b0, 4'h2, DATA_ZERO);
      chb(err, 1'b1);
      $display("test registers done");
      // ch0 and ch1 complementary, ch0 primary idles high
      apb(1'b1, OFS_OUTCTL, 32'h0001_0033);
      apb(1'b1, OFS_BRAKEDT, 32'h010C_1405);
      rdc(OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
      cyc(10);
      @(posedge pclk);
      ref_wave <= 4'h3;
      cyc(DT);
      chk(32'(p_out[1:0]), 32'h0000_0000);
      chk(32'(c_out[1:0]), 32'h0000_0000);
      cyc(4);
      chk(32'(p_out[1:0]), 32'h0000_0003);
      @(posedge pclk);
      ref_wave <= 4'h0;
      cyc(DT);
      chk(32'(c_out[1:0]), 32'h0000_0000);
      cyc(4);
      chk(32'(c_out[1:0]), 32'h0000_0003);
      // pulse shorter than the dead time must vanish
      @(posedge pclk);
      ref_wave <= 4'h3;
      seen = 2'h0;
      for (int i = 0; i < 16; i++) begin
         @(posedge pclk);
         seen = seen | p_out[1:0];
         if (i == 2) begin
            ref_wave <= 4'h0;
         end
      end
      chk(32'(seen), 32'h0000_0000);
      $display("test dead time done");
      apb(1'b1, OFS_OUTCTL, 32'h0001_0233);
      @(posedge pclk);
      ref_wave <= 4'h4;
      cyc(4);
      chb(c_out[2], 1'b1);
      chb(c_oe[2], 1'b1);
      chb(p_oe[2], 1'b0);
      chb(p_oe[3] | c_oe[3], 1'b0);
      apb(1'b1, OFS_OUTCTL, 32'h0001_0A33);
      cyc(4);
      chb(c_out[2], 1'b0);
      apb(1'b1, OFS_BRAKEDT, 32'h010C_1C05);
      cyc(3);
      chb(p_oe[2], 1'b1);
      chb(p_out[2], 1'b0);
      chb(p_oe[3] | c_oe[3], 1'b0);
      $display("test redirection done");
      @(posedge pclk);
      f1 <= 1'b1;
      #1;
      chb(main_out_en, 1'b0);
      chb(c_out[0], 1'b0);
      cyc(DT + 6);
      chb(p_out[0], 1'b1);
      chb(p_oe[0], 1'b1);
      chb(c_out[0], 1'b0);
      rdc(OFS_STATUS, 32'h0000_0005, 32'h0000_001F);
      chb(brake_irq, 1'b1);
      apb(1'b1, OFS_BRAKEDT, 32'h010C_1C05);
      apb(1'b1, OFS_STATUS, 32'h0000_0001);
      pulse_update();
      rdc(OFS_STATUS, 32'h0000_0005, 32'h0000_001F);
      @(posedge pclk);
      f1 <= 1'b0;
      cyc(2);
      pulse_update();
      chb(main_out_en, 1'b1);
      apb(1'b1, OFS_STATUS, 32'h0000_0001);
      rdc(OFS_STATUS, 32'h0000_0010, 32'h0000_001F);
      chb(brake_irq, 1'b0);
      apb(1'b1, OFS_EVENT, 32'h0000_0002);
      cyc(DT + 6);
      chb(main_out_en, 1'b0);
      chb(p_out[0] | c_out[0], 1'b0);
      rdc(OFS_STATUS, 32'h0000_0002, 32'h0000_001F);
      $display("test brake done");
      @(posedge pclk);
      presetn <= 1'b0;
      cyc(3);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, OFS_BRAKEDT, 32'h0010_0003);
      apb(1'b1, OFS_BRAKEDT, 32'h0020_0007);
      rdc(OFS_BRAKEDT, 32'h0010_0003, 32'h0030_03FF);
      $display("test lock done");
      stop_test();
   end
endmodule : complementary_deadtime_brake_output_tb
`default_nettype wire
